/* tb_top.sv */
`timescale 1ns/100ps

module tb_top;

   // ----------------------------------------------------------------
   // signals and model state
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_FLG [2] = '{8'h38, 8'h0b};
   localparam logic [7:0] OFS_MSK [2] = '{8'h39, 8'h0c};
   localparam logic [7:0] OFS_CS  [2] = '{8'h33, 8'h2e};
   localparam logic [7:0] OFS_CA  [2] = '{8'h36, 8'h2c};
   localparam logic [7:0] OFS_CB  [2] = '{8'h3c, 8'h2b};
   localparam logic [7:0] OFS_CNT [2] = '{8'h32, 8'h2d};
   localparam logic [7:0] GTC     = tpif_pkg::GTC_OFS;
   logic       ref_clk;
   logic       rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       global_irq_en;
   logic [5:0] vector_ack;
   logic [5:0] irq_req;
   wire  [1:0] external_count_pin;
   int         errors;
   int         n_tests;
   int         flg_m [2];
   int         span_q [$];
   int         exp_q [$];

   tpif_ext_src src0_u (.pin(external_count_pin[0]));
   tpif_ext_src src1_u (.pin(external_count_pin[1]));

   tpif_top dut_u (
      .ref_clk            (ref_clk),
      .rst_n              (rst_n),
      .reg_addr           (reg_addr),
      .reg_wdata          (reg_wdata),
      .reg_wr             (reg_wr),
      .reg_rd             (reg_rd),
      .reg_rdata          (reg_rdata),
      .global_irq_en      (global_irq_en),
      .vector_ack         (vector_ack),
      .irq_req            (irq_req),
      .external_count_pin (external_count_pin)
   );

   // 125 MHz clock
   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   // ----------------------------------------------------------------
   // bus, compare and closing tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge ref_clk);
      reg_addr  <= ad;
      reg_wdata <= dt;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // read data is taken in the cycle after the strobe
   task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 dt = reg_rdata;
   endtask : rd

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] v;
      rd(ad, v);
      chk(v, exp);
   endtask : rchk

   task automatic end_sim;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // counts gained across exactly span cycles under one select code
   task automatic rate(input int t, input logic [2:0] cs, input int span,
                       input int exp);
      logic [7:0] c0;
      logic [7:0] c1;
      wr(OFS_CS[t], {5'h00, cs});
      rd(OFS_CNT[t], c0);
      repeat (span - 2) @(posedge ref_clk);
      rd(OFS_CNT[t], c1);
      wr(OFS_CS[t], {5'h00, tpif_pkg::CS_STOP});
      chk(c1 - c0, exp[7:0]);
   endtask : rate

   // pin bursts counted once per selected edge, never divided
   task automatic ext(input int t, input logic [2:0] cs, input int n,
                      input int h);
      logic [7:0] c0;
      logic [7:0] c1;
      wr(OFS_CS[t], {5'h00, cs});
      rd(OFS_CNT[t], c0);
      if (t == 0)
         src0_u.burst(n, h);
      else
         src1_u.burst(n, h);
      repeat (6) @(posedge ref_clk);
      rd(OFS_CNT[t], c1);
      wr(OFS_CS[t], {5'h00, tpif_pkg::CS_STOP});
      chk(c1 - c0, n[7:0]);
   endtask : ext

   task automatic irq_chk(input int t, input logic [2:0] exp);
      repeat (2) @(posedge ref_clk);
      chk({2'h0, irq_req}, {2'h0, 6'(exp) << (3 * t)});
   endtask : irq_chk

   // hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      errors++;
      $display("[ERR] %0t run limit reached", $time);
      end_sim;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] c;
      int         k;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      global_irq_en = 1'b0;
      vector_ack    = 6'h00;
      errors        = 0;
      n_tests       = 0;
      rst_n         = 1'b0;
      void'($urandom(56));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      // reset values and an unmapped place
      rchk(OFS_FLG[0], 8'h00);
      rchk(OFS_FLG[1], 8'h00);
      wr(8'h00, 8'hff);
      rchk(8'h00, 8'h00);
      for (int t = 0; t < 2; t++) begin
         // every internal select code over whole tap periods
         k = 3 + $urandom % 60;
         span_q = '{50, k, 64, 128, 256, 1024};
         exp_q  = '{0, k, 8, 2, 1, 1};
         for (int s = 0; s < 6; s++)
            rate(t, s[2:0], span_q[s], exp_q[s]);
         // wrap through every value: all three events
         wr(OFS_CNT[t], 8'($urandom));
         wr(OFS_CA[t], 8'($urandom));
         wr(OFS_CB[t], 8'($urandom));
         wr(OFS_CS[t], {5'h00, tpif_pkg::CS_DIRECT});
         repeat (300) @(posedge ref_clk);
         wr(OFS_CS[t], {5'h00, tpif_pkg::CS_STOP});
         rd(OFS_CNT[t], c);
         wr(OFS_CA[t], c + 8'h40);
         wr(OFS_CB[t], c + 8'h80);
         flg_m[t] = 7;
         rchk(OFS_FLG[t], 8'(flg_m[t]));
         rchk(OFS_FLG[1 - t], 8'h00);
         wr(OFS_MSK[t], 8'h07);
         irq_chk(t, 3'h0);
         global_irq_en <= 1'b1;
         irq_chk(t, 3'h7);
         wr(OFS_FLG[t], 8'h00);
         rchk(OFS_FLG[t], 8'(flg_m[t]));
         wr(OFS_FLG[t], 8'h02);
         flg_m[t] = 5;
         rchk(OFS_FLG[t], 8'(flg_m[t]));
         @(posedge ref_clk);
         vector_ack <= 6'(1 << (3 * t));
         @(posedge ref_clk);
         vector_ack <= 6'h00;
         flg_m[t] = 4;
         rchk(OFS_FLG[t], 8'(flg_m[t]));
         wr(OFS_MSK[t], 8'h03);
         irq_chk(t, 3'h0);
         wr(OFS_FLG[t], 8'h04);
         flg_m[t] = 0;
         rchk(OFS_FLG[t], 8'(flg_m[t]));
         wr(OFS_MSK[t], 8'h00);
         global_irq_en <= 1'b0;
         // external pin, quick and slow sources, both edge kinds
         ext(t, tpif_pkg::CS_EXT_RISE, 1 + $urandom % 20, 2);
         ext(t, tpif_pkg::CS_EXT_FALL, 1 + $urandom % 20, 5);
         // pin counts may wrap the counter; leave no flag for the next timer
         wr(OFS_FLG[t], 8'h07);
      end
      // prescaler reset self clears; sync hold keeps it and halts taps
      wr(GTC, 8'h01);
      rchk(GTC, 8'h00);
      wr(GTC, 8'h81);
      rchk(GTC, 8'h81);
      rate(0, tpif_pkg::CS_DIV8, 64, 0);
      wr(GTC, 8'h00);
      rchk(GTC, 8'h00);
      rate(1, tpif_pkg::CS_DIV8, 64, 8);
      end_sim;
   end

endmodule : tb_top

/* tpif_ext_src.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// external clock source on one count pin
// ----------------------------------------------------------------
module tpif_ext_src (
   // count pin
   output logic pin
);

   // pin rests low and stable long before and after each burst
   initial pin = 1'b0;

   // n full periods; each half lasts half_cyc system cycles plus 3 ns,
   // so the edges drift against the system clock
   task automatic burst(input int n, input int half_cyc);
      repeat (n) begin
         pin = 1'b1;
         #(half_cyc * 8 + 3);
         pin = 1'b0;
         #(half_cyc * 8 + 3);
      end
   endtask : burst

endmodule : tpif_ext_src

/* tpif_pkg.sv */
package tpif_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FLG_T1_OFS    = 8'h0b; // timer1_irq_flags
   localparam logic [7:0] FLG_T0_OFS    = 8'h38; // timer0_irq_flags
   localparam logic [7:0] GTC_OFS       = 8'h23; // general_timer_control
   localparam logic [7:0] MASK_T0_OFS   = 8'h39; // timer 0 irq enables
   localparam logic [7:0] MASK_T1_OFS   = 8'h0c; // timer 1 irq enables
   localparam logic [7:0] CS_T0_OFS     = 8'h33; // timer 0 clock select
   localparam logic [7:0] CS_T1_OFS     = 8'h2e; // timer 1 clock select
   localparam logic [7:0] CMPA_T0_OFS   = 8'h36;
   localparam logic [7:0] CMPB_T0_OFS   = 8'h3c;
   localparam logic [7:0] CMPA_T1_OFS   = 8'h2c;
   localparam logic [7:0] CMPB_T1_OFS   = 8'h2b;
   localparam logic [7:0] CNT_T0_OFS    = 8'h32;
   localparam logic [7:0] CNT_T1_OFS    = 8'h2d;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         OVF_BIT       = 0;
   localparam int         CMPA_BIT      = 1;
   localparam int         CMPB_BIT      = 2;
   localparam int         PSR_BIT       = 0;
   localparam int         SYNC_BIT      = 7;
   localparam logic [7:0] REG_RST       = 8'h00;

   // ----------------------------------------------------------------
   // clock select codes and prescaler taps
   // ----------------------------------------------------------------
   localparam logic [2:0] CS_STOP       = 3'h0;
   localparam logic [2:0] CS_DIRECT     = 3'h1;
   localparam logic [2:0] CS_DIV8       = 3'h2;
   localparam logic [2:0] CS_DIV64      = 3'h3;
   localparam logic [2:0] CS_DIV256     = 3'h4;
   localparam logic [2:0] CS_DIV1024    = 3'h5;
   localparam logic [2:0] CS_EXT_FALL   = 3'h6;
   localparam logic [2:0] CS_EXT_RISE   = 3'h7;
   localparam logic [9:0] TAP8_MASK     = 10'h007;
   localparam logic [9:0] TAP64_MASK    = 10'h03f;
   localparam logic [9:0] TAP256_MASK   = 10'h0ff;
   localparam logic [9:0] TAP1024_MASK  = 10'h3ff;

endpackage : tpif_pkg

/* tpif_timer.sv */
`timescale 1ns/100ps

// one 8-bit counter with its own clock select, sync and flags
module tpif_timer (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // shared prescaler
   input  wire logic       pre_hold,
   input  wire logic [9:0] pre_cnt,
   // external count pin
   input  wire logic       external_count_pin,
   // configuration
   input  wire logic [2:0] clock_source_select,
   input  wire logic [7:0] compare_value_a,
   input  wire logic [7:0] compare_value_b,
   input  wire logic       cnt_wr,
   input  wire logic [7:0] cnt_wdata,
   // flag clearing
   input  wire logic [2:0] flag_clr,
   // results
   output logic      [7:0] cnt_q,
   output logic      [2:0] flags_q,
   output logic            external_timer_tick
);

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic       pin_lat;
   logic       sync1_q;
   logic       sync2_q;
   logic       prev_q;
   logic       tick;
   logic       ovf_ev;

   // latch open while the clock is high, modelled on the falling edge
   always_ff @(negedge ref_clk or negedge rst_n) begin
      if (!rst_n) pin_lat <= 1'b0;
      else        pin_lat <= external_count_pin;
   end

   // two stage synchroniser then edge history
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= pin_lat;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // edge detector picks the edge by clock select, no prescaling
   always_comb begin
      unique case (clock_source_select)
         tpif_pkg::CS_EXT_RISE: external_timer_tick = sync2_q & ~prev_q;
         tpif_pkg::CS_EXT_FALL: external_timer_tick = ~sync2_q & prev_q;
         default:               external_timer_tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // tick selection
   // ----------------------------------------------------------------
   always_comb begin
      unique case (clock_source_select)
         tpif_pkg::CS_STOP:     tick = 1'b0;
         tpif_pkg::CS_DIRECT:   tick = 1'b1;
         tpif_pkg::CS_DIV8:     tick = !pre_hold &&
            ((pre_cnt & tpif_pkg::TAP8_MASK) == tpif_pkg::TAP8_MASK);
         tpif_pkg::CS_DIV64:    tick = !pre_hold &&
            ((pre_cnt & tpif_pkg::TAP64_MASK) == tpif_pkg::TAP64_MASK);
         tpif_pkg::CS_DIV256:   tick = !pre_hold &&
            ((pre_cnt & tpif_pkg::TAP256_MASK) == tpif_pkg::TAP256_MASK);
         tpif_pkg::CS_DIV1024:  tick = !pre_hold &&
            ((pre_cnt & tpif_pkg::TAP1024_MASK) == tpif_pkg::TAP1024_MASK);
         default:               tick = external_timer_tick;
      endcase
   end

   assign ovf_ev = tick && (cnt_q == 8'hff);

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)      cnt_q <= tpif_pkg::REG_RST;
      else if (cnt_wr) cnt_q <= cnt_wdata;
      else if (tick)   cnt_q <= cnt_q + 8'h01;
   end

   // ----------------------------------------------------------------
   // flags: set beats clear, zero written leaves a flag alone
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= 3'h0;
      end else begin
         flags_q[tpif_pkg::OVF_BIT] <= ovf_ev |
            (flags_q[tpif_pkg::OVF_BIT] & ~flag_clr[tpif_pkg::OVF_BIT]);
         // a compare match only counts on a timer tick, so a stopped
         // counter resting on its compare value does not re-set the flag
         flags_q[tpif_pkg::CMPA_BIT] <= (tick && cnt_q == compare_value_a) |
            (flags_q[tpif_pkg::CMPA_BIT] & ~flag_clr[tpif_pkg::CMPA_BIT]);
         flags_q[tpif_pkg::CMPB_BIT] <= (tick && cnt_q == compare_value_b) |
            (flags_q[tpif_pkg::CMPB_BIT] & ~flag_clr[tpif_pkg::CMPB_BIT]);
      end
   end

endmodule : tpif_timer

/* tpif_top.sv */
// Design decision made here: strobed register access.
`timescale 1ns/100ps

module tpif_top (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // cpu side
   input  wire logic       global_irq_en,
   input  wire logic [5:0] vector_ack,
   output logic      [5:0] irq_req,
   // external count pins
   input  wire logic [1:0] external_count_pin
);

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   logic [2:0] irq_en_q [2];
   logic [2:0] cs_q     [2];
   logic [7:0] cmpa_q   [2];
   logic [7:0] cmpb_q   [2];
   logic [7:0] cnt      [2];
   logic [2:0] flags    [2];
   logic [2:0] clr      [2];
   logic [1:0] cnt_wr;
   logic       sync_hold_mode_q;
   logic       prescaler_reset_bit_q;
   logic [9:0] pre_cnt_q;
   logic       gtc_wr;
   logic [7:0] rdata_d;

   assign gtc_wr = reg_wr && (reg_addr == tpif_pkg::GTC_OFS);

   // sync hold and prescaler reset bits
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_hold_mode_q      <= 1'b0;
         prescaler_reset_bit_q <= 1'b0;
      end else if (gtc_wr) begin
         sync_hold_mode_q      <= reg_wdata[tpif_pkg::SYNC_BIT];
         // only kept while hold mode is written one
         prescaler_reset_bit_q <= reg_wdata[tpif_pkg::SYNC_BIT] &
                                  reg_wdata[tpif_pkg::PSR_BIT];
      end else if (!sync_hold_mode_q) begin
         prescaler_reset_bit_q <= 1'b0;
      end
   end

   // free running shared prescaler, reset by the written bit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         pre_cnt_q <= 10'h000;
      else if (prescaler_reset_bit_q ||
               (gtc_wr && reg_wdata[tpif_pkg::PSR_BIT]))
         pre_cnt_q <= 10'h000;
      else
         pre_cnt_q <= pre_cnt_q + 10'h001;
   end

   // ----------------------------------------------------------------
   // per-timer registers and instances
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         localparam logic [7:0] MASK_OFS = (g == 0) ?
            tpif_pkg::MASK_T0_OFS : tpif_pkg::MASK_T1_OFS;
         localparam logic [7:0] CS_OFS   = (g == 0) ?
            tpif_pkg::CS_T0_OFS : tpif_pkg::CS_T1_OFS;
         localparam logic [7:0] CMPA_OFS = (g == 0) ?
            tpif_pkg::CMPA_T0_OFS : tpif_pkg::CMPA_T1_OFS;
         localparam logic [7:0] CMPB_OFS = (g == 0) ?
            tpif_pkg::CMPB_T0_OFS : tpif_pkg::CMPB_T1_OFS;
         localparam logic [7:0] FLG_OFS  = (g == 0) ?
            tpif_pkg::FLG_T0_OFS : tpif_pkg::FLG_T1_OFS;
         localparam logic [7:0] CNT_OFS  = (g == 0) ?
            tpif_pkg::CNT_T0_OFS : tpif_pkg::CNT_T1_OFS;

         // software writable configuration of this timer
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               irq_en_q[g] <= 3'h0;
               cs_q[g]     <= tpif_pkg::CS_STOP;
               cmpa_q[g]   <= tpif_pkg::REG_RST;
               cmpb_q[g]   <= tpif_pkg::REG_RST;
            end else if (reg_wr) begin
               if (reg_addr == MASK_OFS) irq_en_q[g] <= reg_wdata[2:0];
               if (reg_addr == CS_OFS)   cs_q[g]     <= reg_wdata[2:0];
               if (reg_addr == CMPA_OFS) cmpa_q[g]   <= reg_wdata;
               if (reg_addr == CMPB_OFS) cmpb_q[g]   <= reg_wdata;
            end
         end

         // a one written clears, as does the vector acknowledge
         assign clr[g] = ((reg_wr && reg_addr == FLG_OFS) ?
                          reg_wdata[2:0] : 3'h0) |
                         vector_ack[3*g +: 3];
         assign cnt_wr[g] = reg_wr && (reg_addr == CNT_OFS);

         // irq request gated by enable and global bit
         assign irq_req[3*g +: 3] = flags[g] & irq_en_q[g] &
                                    {3{global_irq_en}};

         tpif_timer u_timer (
            .ref_clk             (ref_clk),
            .rst_n               (rst_n),
            .pre_hold            (prescaler_reset_bit_q),
            .pre_cnt             (pre_cnt_q),
            .external_count_pin  (external_count_pin[g]),
            .clock_source_select (cs_q[g]),
            .compare_value_a     (cmpa_q[g]),
            .compare_value_b     (cmpb_q[g]),
            .cnt_wr              (cnt_wr[g]),
            .cnt_wdata           (reg_wdata),
            .flag_clr            (clr[g]),
            .cnt_q               (cnt[g]),
            .flags_q             (flags[g]),
            .external_timer_tick ()
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // read mux, data one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      unique case (reg_addr)
         tpif_pkg::FLG_T0_OFS:  rdata_d = {5'h00, flags[0]};
         tpif_pkg::FLG_T1_OFS:  rdata_d = {5'h00, flags[1]};
         tpif_pkg::MASK_T0_OFS: rdata_d = {5'h00, irq_en_q[0]};
         tpif_pkg::MASK_T1_OFS: rdata_d = {5'h00, irq_en_q[1]};
         tpif_pkg::CS_T0_OFS:   rdata_d = {5'h00, cs_q[0]};
         tpif_pkg::CS_T1_OFS:   rdata_d = {5'h00, cs_q[1]};
         tpif_pkg::CMPA_T0_OFS: rdata_d = cmpa_q[0];
         tpif_pkg::CMPA_T1_OFS: rdata_d = cmpa_q[1];
         tpif_pkg::CMPB_T0_OFS: rdata_d = cmpb_q[0];
         tpif_pkg::CMPB_T1_OFS: rdata_d = cmpb_q[1];
         tpif_pkg::CNT_T0_OFS:  rdata_d = cnt[0];
         tpif_pkg::CNT_T1_OFS:  rdata_d = cnt[1];
         tpif_pkg::GTC_OFS:     rdata_d = {sync_hold_mode_q, 6'h00,
                                           prescaler_reset_bit_q};
         default:               rdata_d = 8'h00;
      endcase
   end

   // registered read data, zero when no read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)      reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rdata_d;
      else             reg_rdata <= 8'h00;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_hold_write;
      gtc_wr && reg_wdata[tpif_pkg::SYNC_BIT] && reg_wdata[tpif_pkg::PSR_BIT];
   endsequence

   property p_irq_gate;
      @(posedge ref_clk) disable iff (!rst_n)
      irq_req[0] |-> global_irq_en && irq_en_q[0][0] && flags[0][0];
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("overflow irq without all three conditions");

   property p_flag_hi_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == tpif_pkg::FLG_T0_OFS |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_flag_hi_zero: assert property (p_flag_hi_zero)
      else $error("flag register upper bits not zero");

   property p_hold_keeps;
      @(posedge ref_clk) disable iff (!rst_n)
      s_hold_write |=> prescaler_reset_bit_q && pre_cnt_q == 10'h000
                       ##1 (prescaler_reset_bit_q || $past(gtc_wr));
   endproperty
   a_hold_keeps: assert property (p_hold_keeps)
      else $error("prescaler reset not kept in hold mode");

   property p_psr_selfclear;
      @(posedge ref_clk) disable iff (!rst_n)
      gtc_wr && !reg_wdata[tpif_pkg::SYNC_BIT] &&
         (reg_wdata[tpif_pkg::PSR_BIT] || prescaler_reset_bit_q) |=>
         !prescaler_reset_bit_q && pre_cnt_q == 10'h000;
   endproperty
   a_psr_selfclear: assert property (p_psr_selfclear)
      else $error("prescaler reset bit did not clear");

   property p_free_run;
      @(posedge ref_clk) disable iff (!rst_n)
      // sampled reset keeps the release edge out of the check
      rst_n && !prescaler_reset_bit_q && !gtc_wr |=>
         pre_cnt_q == $past(pre_cnt_q) + 10'h001;
   endproperty
   a_free_run: assert property (p_free_run)
      else $error("prescaler did not advance");

   property p_direct;
      @(posedge ref_clk) disable iff (!rst_n)
      cs_q[0] == tpif_pkg::CS_DIRECT && !cnt_wr[0] && $stable(cs_q[0])
         |=> cnt[0] == $past(cnt[0]) + 8'h01;
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct clock did not count");

   property p_stop;
      @(posedge ref_clk) disable iff (!rst_n)
      cs_q[1] == tpif_pkg::CS_STOP && !cnt_wr[1] |=> $stable(cnt[1]);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stopped timer counted");

   property p_cmp_a_set;
      @(posedge ref_clk) disable iff (!rst_n)
      cs_q[0] == tpif_pkg::CS_DIRECT && cnt[0] == cmpa_q[0] |=> flags[0][1];
   endproperty
   a_cmp_a_set: assert property (p_cmp_a_set)
      else $error("compare A flag not set on match");

   property p_cmp_b_set;
      @(posedge ref_clk) disable iff (!rst_n)
      cs_q[1] == tpif_pkg::CS_DIRECT && cnt[1] == cmpb_q[1] |=> flags[1][2];
   endproperty
   a_cmp_b_set: assert property (p_cmp_b_set)
      else $error("compare B flag not set on match");

   property p_zero_write;
      @(posedge ref_clk) disable iff (!rst_n)
      reg_wr && reg_addr == tpif_pkg::FLG_T0_OFS && reg_wdata[0] == 1'b0
         && flags[0][0] && vector_ack[0] == 1'b0 |=> flags[0][0];
   endproperty
   a_zero_write: assert property (p_zero_write)
      else $error("flag lost on zero write");

   property p_flag_hi_zero1;
      @(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == tpif_pkg::FLG_T1_OFS |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_flag_hi_zero1: assert property (p_flag_hi_zero1)
      else $error("timer 1 flag upper bits not zero");

   property p_irq_cmp_a;
      @(posedge ref_clk) disable iff (!rst_n)
      irq_req[1] |-> global_irq_en && irq_en_q[0][1] && flags[0][1];
   endproperty
   a_irq_cmp_a: assert property (p_irq_cmp_a)
      else $error("compare A irq without all three conditions");

   property p_irq_cmp_b;
      @(posedge ref_clk) disable iff (!rst_n)
      irq_req[5] |-> global_irq_en && irq_en_q[1][2] && flags[1][2];
   endproperty
   a_irq_cmp_b: assert property (p_irq_cmp_b)
      else $error("compare B irq without all three conditions");

   property p_ovf_set;
      @(posedge ref_clk) disable iff (!rst_n)
      cs_q[0] == tpif_pkg::CS_DIRECT && cnt[0] == 8'hff |=> flags[0][0];
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow flag not set on wrap");

   property p_wr_clear_a;
      @(posedge ref_clk) disable iff (!rst_n)
      reg_wr && reg_addr == tpif_pkg::FLG_T0_OFS && reg_wdata[1] &&
         cs_q[0] == tpif_pkg::CS_STOP |=> !flags[0][1];
   endproperty
   a_wr_clear_a: assert property (p_wr_clear_a)
      else $error("compare A flag not cleared by a written one");

   property p_vec_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      vector_ack[0] && cs_q[0] == tpif_pkg::CS_STOP |=> !flags[0][0];
   endproperty
   a_vec_clear: assert property (p_vec_clear)
      else $error("overflow flag not cleared by vector");

   property p_hold_halts;
      @(posedge ref_clk) disable iff (!rst_n)
      prescaler_reset_bit_q |-> pre_cnt_q == 10'h000;
   endproperty
   a_hold_halts: assert property (p_hold_halts)
      else $error("prescaler ran while held in reset");

endmodule : tpif_top
